// file: logic/frac_round_pkg.sv
package frac_round_pkg;

  localparam int ACC_W = 48;
  localparam int PROD_W = 64;
  localparam int KEEP40_W = 40;
  localparam int DROP40_W = 24;
  localparam int DROP32_W = 8;
  localparam int DROP16_W = 24;
  localparam int KEEP32_W = 32;
  localparam int KEEP16_W = 16;
  localparam int MASK_W = 16;
  localparam int MASK_EN_BIT = 5;
  localparam logic [15:0] MASK_RST = 16'h0000;
  localparam logic [15:0] MASK_UPPER = 16'hFFFF;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

  typedef enum logic [1:0] {
    EA_IND = 2'b00,
    EA_POSTINC = 2'b01,
    EA_PREDEC = 2'b10,
    EA_DISP = 2'b11
  } ea_mode_e;

  typedef enum logic [1:0] {
    OP_MAC = 2'b00,
    OP_MSUB = 2'b01,
    OP_SMUL = 2'b10,
    OP_UMUL = 2'b11
  } mul_op_e;

  typedef enum logic [1:0] {
    SCL_NONE = 2'b00,
    SCL_LEFT = 2'b01,
    SCL_RIGHT = 2'b10,
    SCL_KEEP = 2'b11
  } scale_e;

  typedef struct packed {
    logic sign_mode;
    logic frac_mode;
    logic round_mode;
  } mode_s;

  typedef struct packed {
    logic [15:0] mask;
    logic prod_v;
    logic [63:0] prod;
    logic store_v;
    logic [31:0] store;
    logic ea_v;
    logic [31:0] op_addr;
    logic [31:0] an;
    logic an_we;
  } state_s;

  // 32-bit address window word: upper half all ones, lower half the 16-bit mask
  function automatic logic [31:0] window_word(input logic [15:0] m);
    return {MASK_UPPER, m};
  endfunction : window_word

endpackage : frac_round_pkg

// file: logic/rne_round.sv
`timescale 1ns/1ps
module rne_round #(
  parameter int IN_W = 64,
  parameter int DROP_W = 24
) (
  input wire logic [IN_W-1:0] i_val,
  output logic [IN_W-DROP_W-1:0] o_res
);
  localparam int KEEP_W = IN_W - DROP_W;
  localparam logic [DROP_W-1:0] HALF = {1'b1, {(DROP_W-1){1'b0}}};

  logic [KEEP_W-1:0] upper;
  logic [DROP_W-1:0] lower;
  logic up;

  assign upper = i_val[IN_W-1:DROP_W];
  assign lower = i_val[DROP_W-1:0];
  // below half keeps, above half bumps, tie goes to even
  assign up = (lower > HALF) || ((lower == HALF) && upper[0]);
  assign o_res = upper + KEEP_W'(up);
endmodule : rne_round

// file: logic/addr_window.sv
`timescale 1ns/1ps
module addr_window
  import frac_round_pkg::*;
(
  input wire ea_mode_e i_mode,
  input wire logic [31:0] i_an,
  input wire logic [15:0] i_disp,
  input wire logic i_en,
  input wire logic [15:0] i_mask,
  output logic [31:0] o_op_addr,
  output logic [31:0] o_an,
  output logic o_an_we
);
  logic [31:0] win;
  logic [31:0] inc;
  logic [31:0] dec;
  logic [31:0] dsp;

  always_comb begin
    win = i_en ? window_word(i_mask) : 32'hFFFF_FFFF; // RQ12 RQ21
    inc = i_an + ADDR_STEP;
    dec = i_an - ADDR_STEP;
    dsp = i_an + {{16{i_disp[15]}}, i_disp};
    o_an = i_an;
    o_an_we = 1'b0;
    unique case (i_mode)
      EA_IND: begin
        o_op_addr = i_an & win; // RQ14
      end
      EA_POSTINC: begin
        o_op_addr = i_an; // RQ15
        o_an = inc & win; // RQ15
        o_an_we = 1'b1;
      end
      EA_PREDEC: begin
        o_op_addr = dec & win; // RQ16
        o_an = dec & win; // RQ16
        o_an_we = 1'b1;
      end
      EA_DISP: begin
        o_op_addr = dsp & win; // RQ17
      end
    endcase
  end
endmodule : addr_window

// file: logic/frac_round_and_addr_mask.sv
// Summary of operation
// RQ1: frac store, sign-mode clear: low 8 accumulator bits round 32-bit fraction.
// RQ2: frac store, sign-mode set: low 24 bits round a 16-bit fraction.
// RQ3: frac 32-bit multiply-accumulate, round bit clear: keep upper 40 product bits.
// RQ4: round bit set: round 64-bit product to 40 bits, nearest even.
// RQ5: discarded part below half leaves retained part unchanged.
// RQ6: discarded part above half increments retained part.
// RQ7: exact half increments only when retained lsb is one.
// RQ8: integer multiplies treat operands as integers in any mode.
// RQ9: in fractional mode the product scale shift is ignored.
// RQ10: window register load keeps only low 16 source bits.
// RQ11: window register read gives stored 16 bits, upper half all ones.
// RQ12: masked address is ANDed with ones upper half, window lower half.
// RQ13: masking used only when extension word bit 5 is set.
// RQ14: register indirect: address register ANDed with window.
// RQ15: post-increment: address is register; register becomes (reg+4) masked.
// RQ16: pre-decrement: address and register both (reg-4) masked.
// RQ17: displacement: register plus sign-extended 16-bit offset, masked.
// RQ18: software zeroes status, moves state exactly, restores status last; bench mask_load leaves mode bits cleared.
// RQ19: sign-mode clear store rounds only with round bit set, else truncates.
// RQ20: store rounding never changes the accumulator itself.
// RQ21: mask bit clear: addresses and updates computed without the window.
`timescale 1ns/1ps
module frac_round_and_addr_mask
  import frac_round_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire mode_s i_mode,
  input wire logic i_prod_valid,
  input wire mul_op_e i_prod_op,
  input wire logic i_prod_long,
  input wire scale_e i_prod_scale,
  input wire logic [63:0] i_prod,
  input wire logic i_store_valid,
  input wire logic [47:0] i_acc,
  input wire logic i_mask_wr,
  input wire logic [31:0] i_mask_wdata,
  input wire logic i_ea_valid,
  input wire ea_mode_e i_ea_mode,
  input wire logic [31:0] i_ea_an,
  input wire logic [15:0] i_ea_disp,
  input wire logic [15:0] i_ext_word,
  output logic o_prod_valid,
  output logic [63:0] o_prod_res,
  output logic o_store_valid,
  output logic [31:0] o_store_data,
  output logic [31:0] o_mask_rdata,
  output logic o_ea_valid,
  output logic [31:0] o_op_addr,
  output logic [31:0] o_an_upd,
  output logic o_an_we
);

  ////////////////////////////////////////////////////////////////
  // rounding units

  logic [39:0] prod_rnd;
  logic [31:0] st32_rnd;
  logic [15:0] st16_rnd;

  rne_round #(
    .IN_W(PROD_W),
    .DROP_W(DROP40_W)
  ) u_prod_rnd (
    .i_val(i_prod),
    .o_res(prod_rnd)
  );

  rne_round #(
    .IN_W(KEEP40_W),
    .DROP_W(DROP32_W)
  ) u_st32_rnd (
    .i_val(i_acc[39:0]),
    .o_res(st32_rnd)
  );

  rne_round #(
    .IN_W(KEEP40_W),
    .DROP_W(DROP16_W)
  ) u_st16_rnd (
    .i_val(i_acc[39:0]),
    .o_res(st16_rnd)
  );

  ////////////////////////////////////////////////////////////////
  // address window path

  state_s s_r;
  state_s s_nxt;
  logic mask_en;
  logic [31:0] ea_op_addr;
  logic [31:0] ea_an;
  logic ea_we;

  assign mask_en = i_ext_word[MASK_EN_BIT]; // RQ13

  addr_window u_addr (
    .i_mode(i_ea_mode),
    .i_an(i_ea_an),
    .i_disp(i_ea_disp),
    .i_en(mask_en),
    .i_mask(s_r.mask),
    .o_op_addr(ea_op_addr),
    .o_an(ea_an),
    .o_an_we(ea_we)
  );

  ////////////////////////////////////////////////////////////////
  // product path helpers

  logic mac_op;
  logic [63:0] scaled;

  assign mac_op = (i_prod_op == OP_MAC) || (i_prod_op == OP_MSUB);

  always_comb begin
    unique case (i_prod_scale)
      SCL_LEFT: begin
        scaled = {i_prod[62:0], 1'b0};
      end
      SCL_RIGHT: begin
        scaled = {i_prod[63] & ~i_mode.sign_mode, i_prod[63:1]};
      end
      default: begin
        scaled = i_prod;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.prod_v = 1'b0;
    s_nxt.store_v = 1'b0;
    s_nxt.ea_v = 1'b0;
    s_nxt.an_we = 1'b0;
    if (i_mask_wr) begin
      s_nxt.mask = i_mask_wdata[15:0]; // RQ10
    end
    if (i_prod_valid) begin
      s_nxt.prod_v = 1'b1;
      if (!mac_op) begin
        s_nxt.prod = i_prod; // RQ8
      end else if (!i_mode.frac_mode) begin
        s_nxt.prod = scaled;
      end else if (!i_prod_long) begin
        s_nxt.prod = i_prod; // RQ9
      end else if (i_mode.round_mode) begin
        s_nxt.prod = {prod_rnd, {DROP40_W{1'b0}}}; // RQ4 RQ5 RQ6 RQ7 RQ9
      end else begin
        s_nxt.prod = {i_prod[63:24], {DROP40_W{1'b0}}}; // RQ3 RQ9
      end
    end
    if (i_store_valid) begin
      s_nxt.store_v = 1'b1;
      // accumulator input is only read, never written back
      if (!i_mode.frac_mode) begin
        s_nxt.store = i_acc[31:0]; // RQ20
      end else if (i_mode.sign_mode) begin
        s_nxt.store = {16'h0000, st16_rnd}; // RQ2
      end else if (i_mode.round_mode) begin
        s_nxt.store = st32_rnd; // RQ1 RQ19
      end else begin
        s_nxt.store = i_acc[39:8]; // RQ19
      end
    end
    if (i_ea_valid) begin
      s_nxt.ea_v = 1'b1;
      s_nxt.op_addr = ea_op_addr;
      s_nxt.an = ea_an;
      s_nxt.an_we = ea_we;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.mask <= MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign o_prod_valid = s_r.prod_v;
  assign o_prod_res = s_r.prod;
  assign o_store_valid = s_r.store_v;
  assign o_store_data = s_r.store;
  assign o_mask_rdata = window_word(s_r.mask); // RQ11
  assign o_ea_valid = s_r.ea_v;
  assign o_op_addr = s_r.op_addr;
  assign o_an_upd = s_r.an;
  assign o_an_we = s_r.an_we;

  ////////////////////////////////////////////////////////////////
  // checks

  logic frac_long_mac;
  logic [23:0] low24;

  assign frac_long_mac = i_prod_valid && mac_op && i_mode.frac_mode
    && i_prod_long;
  assign low24 = i_prod[23:0];

  store16_zero_a: assert property ( // RQ2
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && i_mode.sign_mode
    |=> o_store_valid && (o_store_data[31:16] == 16'h0000)
  ) else $error("16-bit store upper half not zero");

  store32_trunc_a: assert property ( // RQ19
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && !i_mode.sign_mode
      && !i_mode.round_mode
    |=> o_store_data == $past(i_acc[39:8])
  ) else $error("unrounded 32-bit store wrong");

  store32_round_a: assert property ( // RQ1
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && !i_mode.sign_mode
      && i_mode.round_mode && (i_acc[7:0] > 8'h80)
    |=> o_store_data == $past(i_acc[39:8]) + 32'h0000_0001
  ) else $error("32-bit store not rounded up");

  prod_trunc_a: assert property ( // RQ3
    @(posedge i_mclk) disable iff (!i_rstn)
    frac_long_mac && !i_mode.round_mode
    |=> o_prod_res == {$past(i_prod[63:24]), 24'h00_0000}
  ) else $error("product not truncated to 40 bits");

  rne_below_a: assert property ( // RQ5
    @(posedge i_mclk) disable iff (!i_rstn)
    frac_long_mac && i_mode.round_mode && (low24 < 24'h80_0000)
    |=> o_prod_res[63:24] == $past(i_prod[63:24])
  ) else $error("below half changed retained bits");

  rne_above_a: assert property ( // RQ6
    @(posedge i_mclk) disable iff (!i_rstn)
    frac_long_mac && i_mode.round_mode && (low24 > 24'h80_0000)
    |=> o_prod_res[63:24] == $past(i_prod[63:24]) + 40'h00_0000_0001
  ) else $error("above half not rounded up");

  rne_tie_a: assert property ( // RQ7
    @(posedge i_mclk) disable iff (!i_rstn)
    frac_long_mac && i_mode.round_mode && (low24 == 24'h80_0000)
    |=> !o_prod_res[24] && (o_prod_res[23:0] == 24'h00_0000)
  ) else $error("tie not rounded to even");

  int_mul_a: assert property ( // RQ8
    @(posedge i_mclk) disable iff (!i_rstn)
    i_prod_valid && !mac_op
    |=> o_prod_valid && (o_prod_res == $past(i_prod))
  ) else $error("integer multiply altered");

  scale_ignored_a: assert property ( // RQ9
    @(posedge i_mclk) disable iff (!i_rstn)
    i_prod_valid && mac_op && i_mode.frac_mode && !i_prod_long
    |=> o_prod_res == $past(i_prod)
  ) else $error("scale applied in fractional mode");

  mask_load_a: assert property ( // RQ10
    @(posedge i_mclk) disable iff (!i_rstn)
    i_mask_wr
    |=> o_mask_rdata == {16'hFFFF, $past(i_mask_wdata[15:0])}
  ) else $error("window load or read wrong");

  mask_hold_a: assert property ( // RQ11
    @(posedge i_mclk) disable iff (!i_rstn)
    !i_mask_wr |=> $stable(o_mask_rdata) && (o_mask_rdata[31:16] == 16'hFFFF)
  ) else $error("window read changed without load");

  postinc_mask_a: assert property ( // RQ15
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && mask_en && (i_ea_mode == EA_POSTINC)
    |=> (o_op_addr == $past(i_ea_an)) && o_an_we
      && (o_an_upd == (($past(i_ea_an) + 32'h0000_0004) & $past(o_mask_rdata)))
  ) else $error("post-increment window update wrong");

  predec_mask_a: assert property ( // RQ16
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && mask_en && (i_ea_mode == EA_PREDEC)
    |=> (o_op_addr == o_an_upd)
      && (o_op_addr == (($past(i_ea_an) - 32'h0000_0004) & $past(o_mask_rdata)))
  ) else $error("pre-decrement window address wrong");

  nomask_ind_a: assert property ( // RQ21
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && !mask_en && (i_ea_mode == EA_IND)
    |=> (o_op_addr == $past(i_ea_an)) && !o_an_we
  ) else $error("window applied while disabled");

  ind_mask_a: assert property ( // RQ14
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && mask_en && (i_ea_mode == EA_IND)
    |=> o_ea_valid && !o_an_we
      && (o_op_addr == ($past(i_ea_an) & $past(o_mask_rdata)))
  ) else $error("indirect window address wrong");

  disp_mask_a: assert property ( // RQ17
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && mask_en && (i_ea_mode == EA_DISP)
    |=> !o_an_we && (o_op_addr == (($past(i_ea_an)
      + {{16{$past(i_ea_disp[15])}}, $past(i_ea_disp)}) & $past(o_mask_rdata)))
  ) else $error("displacement window address wrong");

  window_upper_a: assert property ( // RQ12
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && mask_en && (i_ea_mode == EA_IND)
    |=> (o_op_addr[31:16] == $past(i_ea_an[31:16]))
      && ((o_op_addr[15:0] & ~$past(o_mask_rdata[15:0])) == 16'h0000)
  ) else $error("window upper half not all ones");

  nomask_post_a: assert property ( // RQ21
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && !mask_en && (i_ea_mode == EA_POSTINC)
    |=> (o_op_addr == $past(i_ea_an)) && o_an_we
      && (o_an_upd == $past(i_ea_an) + 32'h0000_0004)
  ) else $error("post-increment changed while window off");

  nomask_pre_a: assert property ( // RQ13
    @(posedge i_mclk) disable iff (!i_rstn)
    i_ea_valid && !mask_en && (i_ea_mode == EA_PREDEC)
    |=> (o_op_addr == $past(i_ea_an) - 32'h0000_0004) && (o_an_upd == o_op_addr)
  ) else $error("pre-decrement masked without enable bit");

  store16_keep_a: assert property ( // RQ2
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && i_mode.sign_mode
      && (i_acc[23:0] < 24'h80_0000)
    |=> o_store_data == {16'h0000, $past(i_acc[39:24])}
  ) else $error("16-bit store below half changed");

  store16_bump_a: assert property ( // RQ2
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && i_mode.sign_mode
      && (i_acc[23:0] > 24'h80_0000)
    |=> o_store_data[15:0] == $past(i_acc[39:24]) + 16'h0001
  ) else $error("16-bit store above half not rounded up");

  store32_tie_a: assert property ( // RQ1
    @(posedge i_mclk) disable iff (!i_rstn)
    i_store_valid && i_mode.frac_mode && !i_mode.sign_mode
      && i_mode.round_mode && (i_acc[7:0] == 8'h80)
    |=> !o_store_data[0]
  ) else $error("32-bit store tie not even");

endmodule : frac_round_and_addr_mask

// file: bench/core_side.sv
`timescale 1ns/1ps
module core_side
  import frac_round_pkg::*;
(
  input wire logic i_mclk,
  output mode_s o_mode,
  output logic o_prod_valid,
  output mul_op_e o_prod_op,
  output logic o_prod_long,
  output scale_e o_prod_scale,
  output logic [63:0] o_prod,
  output logic o_store_valid,
  output logic [47:0] o_acc,
  output logic o_mask_wr,
  output logic [31:0] o_mask_wdata,
  output logic o_ea_valid,
  output ea_mode_e o_ea_mode,
  output logic [31:0] o_ea_an,
  output logic [15:0] o_ea_disp,
  output logic [15:0] o_ext_word
);
  initial begin
    {o_mode, o_prod_valid, o_prod_long, o_prod, o_store_valid, o_acc, o_mask_wr} = '0;
    {o_mask_wdata, o_ea_valid, o_ea_an, o_ea_disp, o_ext_word} = '0;
    o_prod_op = OP_MAC;
    o_prod_scale = SCL_NONE;
    o_ea_mode = EA_IND;
  end

  // product request, data inverted once released
  task automatic prod_req(input mode_s m, input mul_op_e op, input scale_e sc,
                          input logic lg, input logic [63:0] p);
    @(posedge i_mclk);
    o_mode <= m;
    o_prod_op <= op;
    o_prod_long <= lg;
    o_prod_scale <= sc;
    o_prod <= p;
    o_prod_valid <= 1'b1;
    @(posedge i_mclk);
    o_prod_valid <= 1'b0;
    o_prod <= ~p;
    #1;
  endtask : prod_req

  task automatic store_req(input mode_s m, input logic [47:0] a);
    @(posedge i_mclk);
    o_mode <= m;
    o_acc <= a;
    o_store_valid <= 1'b1;
    @(posedge i_mclk);
    o_store_valid <= 1'b0;
    o_acc <= ~a;
    #1;
  endtask : store_req

  // mode bits cleared for the window move and left cleared after it
  task automatic mask_load(input logic [31:0] v);
    @(posedge i_mclk);
    o_mode <= '0;
    o_mask_wdata <= v;
    o_mask_wr <= 1'b1;
    @(posedge i_mclk);
    o_mask_wr <= 1'b0;
    o_mask_wdata <= ~v;
    #1;
  endtask : mask_load

  task automatic ea_req(input ea_mode_e md, input logic [31:0] a, input logic [15:0] d,
                        input logic [15:0] x);
    @(posedge i_mclk);
    o_ea_mode <= md;
    o_ea_an <= a;
    o_ea_disp <= d;
    o_ext_word <= x;
    o_ea_valid <= 1'b1;
    @(posedge i_mclk);
    o_ea_valid <= 1'b0;
    o_ea_an <= ~a;
    #1;
  endtask : ea_req
endmodule : core_side

// file: bench/frac_round_and_addr_mask_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module frac_round_and_addr_mask_tb;
  import frac_round_pkg::*;
  logic i_mclk, i_rstn;
  int err_total = 0;
  int n_tests = 0;
  mode_s i_mode;
  mul_op_e i_prod_op;
  scale_e i_prod_scale;
  ea_mode_e i_ea_mode;
  logic i_prod_valid, i_prod_long, i_store_valid, i_mask_wr, i_ea_valid;
  logic o_prod_valid, o_store_valid, o_ea_valid, o_an_we;
  logic [63:0] i_prod, o_prod_res;
  logic [47:0] i_acc;
  logic [31:0] i_mask_wdata, i_ea_an, o_store_data, o_mask_rdata, o_op_addr, o_an_upd;
  logic [15:0] i_ea_disp, i_ext_word;
  logic [63:0] pt [4] = '{64'h1234_5678_9A7F_FFFF, 64'h1234_5678_9A80_0001,
                          64'h1234_5678_9A80_0000, 64'h1234_5678_9B80_0000};
  logic [47:0] at [3] = '{48'h0012_3456_7880, 48'h0012_3580_0081, 48'h0012_3180_0000};

  core_side i_core_side (.i_mclk(i_mclk), .o_mode(i_mode), .o_prod_valid(i_prod_valid),
    .o_prod_op(i_prod_op), .o_prod_long(i_prod_long), .o_prod_scale(i_prod_scale),
    .o_prod(i_prod), .o_store_valid(i_store_valid), .o_acc(i_acc), .o_mask_wr(i_mask_wr),
    .o_mask_wdata(i_mask_wdata), .o_ea_valid(i_ea_valid), .o_ea_mode(i_ea_mode),
    .o_ea_an(i_ea_an), .o_ea_disp(i_ea_disp), .o_ext_word(i_ext_word));

  frac_round_and_addr_mask i_frac_round_and_addr_mask (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_mode(i_mode), .i_prod_valid(i_prod_valid), .i_prod_op(i_prod_op),
    .i_prod_long(i_prod_long), .i_prod_scale(i_prod_scale), .i_prod(i_prod),
    .i_store_valid(i_store_valid), .i_acc(i_acc), .i_mask_wr(i_mask_wr),
    .i_mask_wdata(i_mask_wdata), .i_ea_valid(i_ea_valid), .i_ea_mode(i_ea_mode),
    .i_ea_an(i_ea_an), .i_ea_disp(i_ea_disp), .i_ext_word(i_ext_word),
    .o_prod_valid(o_prod_valid), .o_prod_res(o_prod_res), .o_store_valid(o_store_valid),
    .o_store_data(o_store_data), .o_mask_rdata(o_mask_rdata), .o_ea_valid(o_ea_valid),
    .o_op_addr(o_op_addr), .o_an_upd(o_an_upd), .o_an_we(o_an_we));

  ////////////////////////////////////////////////////////////////////////////////
  // nearest-even rounding, dw low bits dropped
  function automatic logic [63:0] rnd(input logic [63:0] v, input int dw, input logic en);
    logic [63:0] h, d, k;
    h = 64'h1 << (dw - 1);
    d = v & ((h << 1) - 64'h1);
    k = v >> dw;
    return k + 64'((en && (d > h || (d == h && k[0]))));
  endfunction : rnd

  function automatic logic [64:0] ea_exp(input ea_mode_e m, input logic [31:0] a,
                                         input logic en);
    logic [31:0] w, op, up;
    w = en ? 32'hFFFF_00FF : 32'hFFFF_FFFF;
    op = (m == EA_PREDEC) ? a - 32'h4 : (m == EA_DISP) ? a - 32'h10 : a;
    up = (m == EA_POSTINC) ? a + 32'h4 : op;
    if (m == EA_POSTINC || m == EA_PREDEC) begin
      return {(m == EA_POSTINC) ? a : op & w, up & w, 1'b1};
    end
    return {op & w, a, 1'b0};
  endfunction : ea_exp

  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    `CHK("reset window", 32'hFFFF_0000, o_mask_rdata)
    `CHK("reset valid", 1'b0, o_prod_valid)
  endtask : t_reset

  task t_product;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        i_core_side.prod_req(mode_s'{1'b0, 1'b1, r[0]}, r ? OP_MAC : OP_MSUB,
                             r ? SCL_RIGHT : SCL_LEFT, 1'b1, pt[i]);
        `CHK("prod valid", 1'b1, o_prod_valid)
        `CHK("frac prod", rnd(pt[i], 24, r[0]) << 24, o_prod_res)
      end
    end
  endtask : t_product

  task t_intmul;
    i_core_side.prod_req(mode_s'{1'b0, 1'b1, 1'b1}, OP_SMUL, SCL_LEFT, 1'b1, pt[3]);
    `CHK("signed mul", pt[3], o_prod_res)
    i_core_side.prod_req(mode_s'{1'b1, 1'b1, 1'b1}, OP_UMUL, SCL_RIGHT, 1'b1, pt[1]);
    `CHK("unsigned mul", pt[1], o_prod_res)
    i_core_side.prod_req(mode_s'{1'b0, 1'b1, 1'b1}, OP_MAC, SCL_LEFT, 1'b0, pt[1]);
    `CHK("frac word mac", pt[1], o_prod_res)
    i_core_side.prod_req(mode_s'{1'b0, 1'b0, 1'b0}, OP_MSUB, SCL_LEFT, 1'b1, pt[1]);
    `CHK("int mac left", pt[1] << 1, o_prod_res)
    i_core_side.prod_req(mode_s'{1'b0, 1'b0, 1'b0}, OP_MAC, SCL_RIGHT, 1'b1, ~pt[3]);
    `CHK("int mac right", 64'h8000_0000_0000_0000 | (~pt[3] >> 1), o_prod_res)
  endtask : t_intmul

  task t_store;
    for (int i = 0; i < 3; i++) begin
      i_core_side.store_req(mode_s'{1'b1, 1'b1, 1'b0}, at[i]);
      `CHK("store valid", 1'b1, o_store_valid)
      `CHK("store16", 32'(rnd(64'(at[i][39:0]), 24, 1'b1)) & 32'h0000_FFFF, o_store_data)
      for (int r = 0; r < 2; r++) begin
        i_core_side.store_req(mode_s'{1'b0, 1'b1, r[0]}, at[i]);
        `CHK("store32", 32'(rnd(64'(at[i][39:0]), 8, r[0])), o_store_data)
      end
    end
    i_core_side.store_req(mode_s'{1'b0, 1'b0, 1'b1}, at[1]);
    `CHK("int store", 32'h3580_0081, o_store_data)
  endtask : t_store

  task t_window;
    i_core_side.mask_load(32'h1234_0F0F);
    `CHK("window rd", 32'hFFFF_0F0F, o_mask_rdata)
    @(posedge i_mclk) i_rstn <= 1'b0;
    @(posedge i_mclk) i_rstn <= 1'b1;
    #1;
    `CHK("window rst", 32'hFFFF_0000, o_mask_rdata)
    i_core_side.mask_load(32'hABCD_00FF);
    `CHK("window rd2", 32'hFFFF_00FF, o_mask_rdata)
  endtask : t_window

  task t_address;
    logic [64:0] ea_want;
    for (int e = 0; e < 2; e++) begin
      for (int k = 0; k < 4; k++) begin
        i_core_side.ea_req(ea_mode_e'(k), 32'h1000_0ABC, 16'hFFF0, e ? 16'h0020 : 16'hFFDF);
        ea_want = ea_exp(ea_mode_e'(k), 32'h1000_0ABC, e[0]);
        `CHK("ea valid", 1'b1, o_ea_valid)
        `CHK("ea", ea_want, {o_op_addr, o_an_upd, o_an_we})
      end
    end
  endtask : t_address

  task conclude;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  initial begin
    i_rstn = 1'b0;
    repeat (4) @(posedge i_mclk);
    i_rstn <= 1'b1;
    #1;
    t_reset;
    t_product;
    t_intmul;
    t_store;
    t_window;
    t_address;
    conclude;
  end

  initial begin
    repeat (5000) @(posedge i_mclk);
    err_total++;
    conclude;
  end
endmodule : frac_round_and_addr_mask_tb
